// ---- common/sfpfe_defines.svh ----
// Purpose: constants for the serial flash pin front end
// Assumes: 100 MHz system clock
// Notes: times in ns, cycle counts derived from them
`ifndef SFPFE_DEFINES_SVH
`define SFPFE_DEFINES_SVH
`define SFPFE_CLK_PERIOD_NS 10
`define SFPFE_HW_RESET_MIN_NS 1000
`define SFPFE_HW_RESET_CYC ((`SFPFE_HW_RESET_MIN_NS + `SFPFE_CLK_PERIOD_NS - 1) / `SFPFE_CLK_PERIOD_NS)
`define SFPFE_SW_RESET_NS 30000
`define SFPFE_SW_RESET_CYC (`SFPFE_SW_RESET_NS / `SFPFE_CLK_PERIOD_NS)
`define SFPFE_OP_ENABLE_RESET 8'h66
`define SFPFE_OP_RESET 8'h99
`define SFPFE_OP_READ_DUAL_OUT 8'h3b
`define SFPFE_OP_READ_DUAL_IO 8'hbb
`define SFPFE_OP_READ_QUAD_OUT 8'h6b
`define SFPFE_OP_READ_QUAD_IO 8'heb
`define SFPFE_FIFO_DEPTH 8
`endif

// ---- common/sfpfe_pkg.sv ----
// Purpose: types for the serial flash pin front end
// Assumes: nothing
// Notes: lane widths fixed at four
package sfpfe_pkg;
  typedef enum logic [1:0] {
    SFPFE_LANE_SINGLE = 2'b00,
    SFPFE_LANE_DUAL = 2'b01,
    SFPFE_LANE_QUAD = 2'b10
  } sfpfe_width_type;
  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } sfpfe_pins_out_type;
  typedef struct packed {
    logic quad_enable_bit;
    logic status_protect_bit;
  } sfpfe_cfg_type;
endpackage

// ---- logic/sfpfe_fifo.sv ----
// Purpose: small valid/ready fifo for read data bytes
// Assumes: single clock
// Notes: honest full and empty
`timescale 1ns/100ps
module sfpfe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  input wire logic flush
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sfpfe_fifo_st_type;
  sfpfe_fifo_st_type st_q, st_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;
  assign in_ready = (st_q.cnt != DEPTH[AW:0]);
  assign out_valid = (st_q.cnt != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[st_q.rp];
  // pointer and count update
  always_comb begin
    st_d = st_q;
    if (push) st_d.wp = st_q.wp + 1'b1;
    if (pop) st_d.rp = st_q.rp + 1'b1;
    st_d.cnt = st_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (flush) st_d = '0;
  end
  // storage and state
  always_ff @(posedge sys_clk) begin
    if (rst) st_q <= '0;
    else st_q <= st_d;
    if (push) mem[st_q.wp] <= in_data;
  end
endmodule

// ---- logic/sfpfe_core.sv ----
// Purpose: serial flash pin front end, device side
// Assumes: pins oversampled by sys_clk, serial clock well below sys_clk/4
// Notes: read bytes come from the array side through a fifo
// What this block does
// - deselected: all output lanes float
// - select low: take instructions, return data
// - ignore instructions until first select fall
// - internal_busy input is not used by this block
// - single lane samples input on rising clock
// - single lane drives output on falling clock
// - dual/quad: in on rise, out on fall
// - quad only with quad enable bit set
// - write protect pin guards status writes
// - pause low floats output, ignores clock
// - pause high resumes the transaction
// - no pause while quad enable set
// - reset pin low one microsecond resets all
// - reset pin works in every state
// - clock idle low or high accepted
// - dual reads use lanes 0 and 1
// - quad reads use lanes 0 to 3
// - enable-reset then reset does software reset
// - software reset blocks instructions thirty microseconds
`timescale 1ns/100ps
`include "sfpfe_defines.svh"
module sfpfe_core
  import sfpfe_pkg::*;
#(
  parameter int HW_RESET_CYC = `SFPFE_HW_RESET_CYC,
  parameter int SW_RESET_CYC = `SFPFE_SW_RESET_CYC,
  parameter int DEPTH = `SFPFE_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic serial_clk,
  input wire logic select_n,
  input wire logic reset_pin_n,
  input wire logic [3:0] lane_in,
  output sfpfe_pkg::sfpfe_pins_out_type pins_out,
  input wire sfpfe_pkg::sfpfe_cfg_type cfg,
  input wire logic internal_busy,
  output logic status_write_allowed,
  output logic [7:0] opcode,
  output logic opcode_valid,
  output logic [7:0] rx_byte,
  output logic rx_byte_valid,
  output logic [1:0] lane_mode,
  output logic frame_end,
  input wire logic rd_valid,
  output logic rd_ready,
  input wire logic [7:0] rd_data,
  output logic device_reset,
  output logic sw_reset_busy
);
  import sfpfe_pkg::*;
  typedef struct packed {
    logic [1:0] clk_s1, clk_s2, clk_s3;
    logic [1:0] sel_s1, sel_s2, sel_s3;
    logic [1:0] rstn_s1, rstn_s2;
    logic [3:0] lin_s1, lin_s2;
    logic armed;
    logic active;
    logic got_op;
    logic [7:0] sh;
    logic [3:0] bits;
    sfpfe_width_type in_w;
    sfpfe_width_type out_w;
    logic out_en;
    logic [7:0] tx;
    logic [3:0] tx_bits;
    logic [3:0] o;
    logic reset_armed;
    logic [31:0] hw_cnt;
    logic [31:0] sw_cnt;
    logic hw_rst;
    logic [7:0] op;
    logic op_v;
    logic [7:0] rxb;
    logic rxb_v;
    logic fend;
  } sfpfe_st_type;
  sfpfe_st_type st_q, st_d;
  logic fifo_valid, fifo_pop;
  logic [7:0] fifo_data;
  // read data buffer toward the serial output
  sfpfe_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
    .sys_clk(sys_clk), .rst(rst | st_q.hw_rst),
    .in_valid(rd_valid), .in_ready(rd_ready), .in_data(rd_data),
    .out_valid(fifo_valid), .out_ready(fifo_pop), .out_data(fifo_data),
    .flush(st_q.fend)
  );
  // bits moved per clock for a lane width
  function automatic logic [3:0] bits_per(input sfpfe_width_type w);
    case (w)
      SFPFE_LANE_DUAL: bits_per = 4'd2;
      SFPFE_LANE_QUAD: bits_per = 4'd4;
      default: bits_per = 4'd1;
    endcase
  endfunction
  logic sel_n, sclk_rise, sclk_fall, pause_n, hold_act, rising, falling, quad_ok;
  logic [7:0] nsh;
  logic [3:0] step;
  always_comb begin
    sel_n = st_q.sel_s2[0];
    quad_ok = cfg.quad_enable_bit;
    pause_n = st_q.lin_s2[3];
    hold_act = !quad_ok && !pause_n && !sel_n;
    sclk_rise = st_q.clk_s2[0] & ~st_q.clk_s3[0];
    sclk_fall = ~st_q.clk_s2[0] & st_q.clk_s3[0];
    rising = sclk_rise && !hold_act;
    falling = sclk_fall && !hold_act;
    step = bits_per(st_q.in_w);
    nsh = st_q.sh;
    st_d = st_q;
    st_d.clk_s1 = {1'b0, serial_clk};
    st_d.clk_s2 = st_q.clk_s1;
    st_d.clk_s3 = st_q.clk_s2;
    st_d.sel_s1 = {1'b0, select_n};
    st_d.sel_s2 = st_q.sel_s1;
    st_d.sel_s3 = st_q.sel_s2;
    st_d.rstn_s1 = {1'b0, reset_pin_n};
    st_d.rstn_s2 = st_q.rstn_s1;
    st_d.lin_s1 = lane_in;
    st_d.lin_s2 = st_q.lin_s1;
    st_d.op_v = 1'b0;
    st_d.rxb_v = 1'b0;
    st_d.fend = 1'b0;
    // hardware reset pin low long enough; no setting masks it
    if (!st_q.rstn_s2[0]) begin
      if (st_q.hw_cnt < HW_RESET_CYC) st_d.hw_cnt = st_q.hw_cnt + 32'd1;
    end else st_d.hw_cnt = '0;
    st_d.hw_rst = (st_q.hw_cnt >= HW_RESET_CYC - 1) && !st_q.rstn_s2[0];
    if (st_q.sw_cnt != '0) st_d.sw_cnt = st_q.sw_cnt - 32'd1;
    // select edges; clock level at the edges is don't-care for modes 0 and 3
    if (!sel_n && st_q.sel_s3[0]) begin
      st_d.armed = 1'b1;
      st_d.active = st_q.armed || 1'b1;
      st_d.got_op = 1'b0;
      st_d.bits = '0;
      st_d.sh = '0;
      st_d.in_w = SFPFE_LANE_SINGLE;
      st_d.out_w = SFPFE_LANE_SINGLE;
      st_d.out_en = 1'b0;
      st_d.tx_bits = '0;
      if (st_q.sw_cnt != '0) st_d.active = 1'b0;
    end
    if (sel_n && !st_q.sel_s3[0]) begin
      st_d.active = 1'b0;
      st_d.out_en = 1'b0;
      st_d.fend = 1'b1;
    end
    // capture on rising serial clock, msb first
    if (st_q.active && !sel_n && rising) begin
      case (st_q.in_w)
        SFPFE_LANE_DUAL: nsh = {st_q.sh[5:0], st_q.lin_s2[1:0]};
        SFPFE_LANE_QUAD: nsh = {st_q.sh[3:0], st_q.lin_s2[3:0]};
        default: nsh = {st_q.sh[6:0], st_q.lin_s2[0]};
      endcase
      st_d.sh = nsh;
      if (st_q.bits + step >= 4'd8) begin
        st_d.bits = '0;
        if (!st_q.got_op) begin
          st_d.got_op = 1'b1;
          st_d.op = nsh;
          st_d.op_v = 1'b1;
          if (nsh == `SFPFE_OP_RESET && st_q.reset_armed) begin
            st_d.sw_cnt = SW_RESET_CYC;
            st_d.active = 1'b0;
          end
          st_d.reset_armed = (nsh == `SFPFE_OP_ENABLE_RESET);
          if (nsh == `SFPFE_OP_READ_DUAL_OUT || nsh == `SFPFE_OP_READ_DUAL_IO) begin
            st_d.out_w = SFPFE_LANE_DUAL;
            if (nsh == `SFPFE_OP_READ_DUAL_IO) st_d.in_w = SFPFE_LANE_DUAL;
          end
          if ((nsh == `SFPFE_OP_READ_QUAD_OUT || nsh == `SFPFE_OP_READ_QUAD_IO) && quad_ok) begin
            st_d.out_w = SFPFE_LANE_QUAD;
            if (nsh == `SFPFE_OP_READ_QUAD_IO) st_d.in_w = SFPFE_LANE_QUAD;
          end
          if ((nsh == `SFPFE_OP_READ_QUAD_OUT || nsh == `SFPFE_OP_READ_QUAD_IO) && !quad_ok)
            st_d.active = 1'b0;
        end else begin
          st_d.rxb = nsh;
          st_d.rxb_v = 1'b1;
        end
      end else st_d.bits = st_q.bits + step;
    end
    // launch on falling serial clock once read data is waiting
    if (st_q.active && !sel_n && falling && st_q.got_op) begin
      if (st_q.tx_bits == '0) begin
        if (fifo_valid) begin
          st_d.out_en = 1'b1;
          st_d.tx = fifo_data << bits_per(st_q.out_w);
          st_d.tx_bits = 4'd8 - bits_per(st_q.out_w);
          st_d.o = (st_q.out_w == SFPFE_LANE_QUAD) ? fifo_data[7:4] :
                   (st_q.out_w == SFPFE_LANE_DUAL) ? {2'b00, fifo_data[7:6]} : {2'b00, fifo_data[7], 1'b0};
        end
      end else begin
        st_d.tx = st_q.tx << bits_per(st_q.out_w);
        st_d.tx_bits = st_q.tx_bits - bits_per(st_q.out_w);
        st_d.o = (st_q.out_w == SFPFE_LANE_QUAD) ? st_q.tx[7:4] :
                 (st_q.out_w == SFPFE_LANE_DUAL) ? {2'b00, st_q.tx[7:6]} : {2'b00, st_q.tx[7], 1'b0};
      end
    end
    if (st_q.hw_rst) begin
      st_d = '0;
      st_d.clk_s1 = st_q.clk_s1;
      st_d.clk_s2 = st_q.clk_s2;
      st_d.clk_s3 = st_q.clk_s3;
      st_d.sel_s1 = {1'b0, select_n};
      st_d.sel_s2 = st_q.sel_s1;
      st_d.sel_s3 = st_q.sel_s2;
      st_d.rstn_s1 = {1'b0, reset_pin_n};
      st_d.rstn_s2 = st_q.rstn_s1;
      st_d.hw_cnt = st_q.hw_cnt;
      st_d.hw_rst = st_d.hw_cnt >= HW_RESET_CYC - 1 && !st_q.rstn_s2[0];
    end
  end
  assign fifo_pop = st_q.active && !sel_n && falling && st_q.got_op && st_q.tx_bits == '0;
  // output lanes; float when deselected or paused
  always_comb begin
    pins_out.o = st_q.o;
    pins_out.oe = '0;
    if (!sel_n && st_q.out_en && !hold_act) begin
      case (st_q.out_w)
        SFPFE_LANE_QUAD: pins_out.oe = 4'hf;
        SFPFE_LANE_DUAL: pins_out.oe = 4'h3;
        default: pins_out.oe = 4'h2;
      endcase
    end
  end
  // write protect pin only counts while lane 2 is not data
  assign status_write_allowed = !(cfg.status_protect_bit && !quad_ok && !st_q.lin_s2[2]);
  assign opcode = st_q.op;
  assign opcode_valid = st_q.op_v;
  assign rx_byte = st_q.rxb;
  assign rx_byte_valid = st_q.rxb_v;
  assign lane_mode = st_q.in_w;
  assign frame_end = st_q.fend;
  assign device_reset = st_q.hw_rst;
  assign sw_reset_busy = (st_q.sw_cnt != '0);
  // single state register
  always_ff @(posedge sys_clk) begin
    if (rst) st_q <= '0;
    else st_q <= st_d;
  end
  logic unused_busy;
  assign unused_busy = internal_busy;
endmodule

// ---- verification/sfpfe_monitor.sv ----
// Purpose: port checks for the pin front end
// Assumes: one clock domain, pins synced within 4 cycles
// Notes: bound onto the core
`timescale 1ns/100ps
module sfpfe_monitor #(
  parameter int HW_RESET_CYC = 8,
  parameter int SW_RESET_CYC = 400
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic select_n,
  input wire logic reset_pin_n,
  input wire logic [3:0] lane_in,
  input wire sfpfe_pkg::sfpfe_pins_out_type pins_out,
  input wire sfpfe_pkg::sfpfe_cfg_type cfg,
  input wire logic status_write_allowed,
  input wire logic opcode_valid,
  input wire logic [1:0] lane_mode,
  input wire logic frame_end,
  input wire logic device_reset,
  input wire logic sw_reset_busy
);
  import sfpfe_pkg::*;
  localparam int SW_LO = SW_RESET_CYC - 2;
  localparam int SW_HI = SW_RESET_CYC + 6;
  logic [15:0] low_q;
  logic [15:0] low_d;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // cycles the reset pin has stayed low
  always_comb low_d = reset_pin_n ? 16'h0 : low_q + 16'h1;
  always_ff @(posedge sys_clk) low_q <= rst ? 16'h0 : low_d;
  // lane, protect and reset relations
  AST_DESEL: assert property (select_n [*4] |-> pins_out.oe == 4'h0) else $error("driven while idle");
  AST_PAUSE: assert property ((!select_n && !lane_in[3] && !cfg.quad_enable_bit) [*4] |-> pins_out.oe == 4'h0)
    else $error("driven while paused");
  AST_QUAD: assert property (!cfg.quad_enable_bit [*4] |-> pins_out.oe[3:2] == 2'h0) else $error("quad off");
  AST_DUAL: assert property (lane_mode == 2'h1 |-> pins_out.oe[3:2] == 2'h0) else $error("dual lanes");
  AST_WP: assert property ((cfg.status_protect_bit && !cfg.quad_enable_bit && !lane_in[2]) [*4]
    |-> !status_write_allowed) else $error("status write not blocked");
  AST_HWRST: assert property (low_q == HW_RESET_CYC + 4 |-> device_reset) else $error("no reset");
  AST_SWBLK: assert property (sw_reset_busy && !$rose(sw_reset_busy) |-> !opcode_valid) else $error("opcode in reset");
  AST_SWEND: assert property ($rose(sw_reset_busy) |-> ##[SW_LO:SW_HI] !sw_reset_busy) else $error("reset span");
  AST_FEND: assert property ($rose(select_n) |-> ##[1:6] frame_end) else $error("no frame end");
  AST_PULSE: assert property (opcode_valid |=> !opcode_valid) else $error("long pulse");
endmodule
bind sfpfe_core sfpfe_monitor #(.HW_RESET_CYC(HW_RESET_CYC), .SW_RESET_CYC(SW_RESET_CYC)) u_mon (
  .sys_clk(sys_clk), .rst(rst), .select_n(select_n), .reset_pin_n(reset_pin_n), .lane_in(lane_in),
  .pins_out(pins_out), .cfg(cfg), .status_write_allowed(status_write_allowed), .opcode_valid(opcode_valid),
  .lane_mode(lane_mode), .frame_end(frame_end), .device_reset(device_reset), .sw_reset_busy(sw_reset_busy));

// ---- verification/sfpfe_host_model.sv ----
// Purpose: spi host model for the pin front end
// Assumes: link clock period 125 ns
// Notes: idle lanes toggle, lanes 2/3 carry protect/pause unless quad
`timescale 1ns/100ps
module sfpfe_host_model (
  output logic serial_clk,
  output logic select_n,
  output logic [3:0] lane_in,
  input wire sfpfe_pkg::sfpfe_pins_out_type pins_out
);
  import sfpfe_pkg::*;
  logic [3:0] drv = 4'h0;
  logic [3:0] drv_en = 4'h0;
  logic wp_n = 1'b1;
  logic pause_n = 1'b1;
  logic quad = 1'b0;
  initial serial_clk = 1'b0;
  initial select_n = 1'b1;
  // device wins, then protect/pause level on lanes 2/3 unless quad, then host, then junk
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_in[i] = pins_out.oe[i] ? pins_out.o[i] : (drv_en[i] ? drv[i] : serial_clk);
    end
    if (!quad && !pins_out.oe[2]) lane_in[2] = wp_n;
    if (!quad && !pins_out.oe[3]) lane_in[3] = pause_n;
  end
  // select fall with clock idle at cpol
  task automatic open_frame(input logic cpol);
    serial_clk = cpol;
    #62.5 select_n = 1'b0;
    #62.5;
  endtask
  // byte out msb first, w lanes, optional pause before beat pz
  task automatic send(input logic [7:0] b, input int w, input int pz);
    for (int k = 8 / w - 1; k >= 0; k--) begin
      serial_clk = 1'b0;
      if (k == pz) begin
        pause_n = 1'b0;
        repeat (4) begin
          #62.5 serial_clk = ~serial_clk;
          drv = ~drv;
        end
        #62.5 pause_n = 1'b1;
      end
      drv_en = 4'((1 << w) - 1);
      drv = 4'(b >> (k * w));
      #62.5 serial_clk = 1'b1;
      #62.5;
    end
    drv_en = 4'h0;
  endtask
  // byte in, sampled at rising edges
  task automatic recv(input int w, output logic [7:0] b);
    b = 8'h0;
    for (int k = 0; k < 8 / w; k++) begin
      serial_clk = 1'b0;
      #62.5 serial_clk = 1'b1;
      b = (b << w) | 8'(w == 1 ? 4'(lane_in[1]) : lane_in & 4'((1 << w) - 1));
      #62.5;
    end
  endtask
  task automatic close_frame(input logic cpol);
    serial_clk = cpol;
    #62.5 select_n = 1'b1;
    #250;
  endtask
endmodule

// ---- verification/testbench.sv ----
// Purpose: self-checking bench for the pin front end
// Assumes: short reset counts by parameter
// Notes: stimulus at falling sys_clk, link traffic from host model
`timescale 1ns/100ps
module testbench;
  import sfpfe_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reset_pin_n = 1'b1;
  logic rd_valid = 1'b0;
  logic [7:0] rd_data = 8'h0;
  sfpfe_cfg_type cfg = '0;
  logic serial_clk, select_n, swa, opv, rxv, fend, rd_ready, dev_rst, sw_busy;
  logic [3:0] lane_in;
  logic [7:0] opcode, got, rxb;
  logic ibusy = 1'b0;
  logic [1:0] lane_mode;
  sfpfe_pins_out_type pins_out;
  int n_mismatch = 0;
  int checks_done = 0;
  int n_op = 0;
  int n_push = 0;
  always #5 sys_clk = ~sys_clk;
  // count opcode pulses and accepted read bytes
  always @(posedge sys_clk) begin
    if (opv === 1'b1) n_op <= n_op + 1;
    if (rd_valid && rd_ready === 1'b1) n_push <= n_push + 1;
  end
  sfpfe_core #(.HW_RESET_CYC(8), .SW_RESET_CYC(400)) u_dut (.sys_clk(sys_clk), .rst(rst),
    .serial_clk(serial_clk), .select_n(select_n), .reset_pin_n(reset_pin_n), .lane_in(lane_in),
    .pins_out(pins_out), .cfg(cfg), .internal_busy(ibusy), .status_write_allowed(swa), .opcode(opcode),
    .opcode_valid(opv), .rx_byte(rxb), .rx_byte_valid(rxv), .lane_mode(lane_mode), .frame_end(fend),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .device_reset(dev_rst), .sw_reset_busy(sw_busy));
  sfpfe_host_model u_host (.serial_clk(serial_clk), .select_n(select_n), .lane_in(lane_in), .pins_out(pins_out));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one-byte frame, expecting ops opcode pulses
  task automatic frame(input logic [7:0] b, input logic cpol, input int pz, input int ops);
    int n0;
    n0 = n_op;
    u_host.open_frame(cpol);
    u_host.send(b, 1, pz);
    #200;
    check(8'(n_op - n0), 8'(ops));
    if (ops > 0) check(opcode, b);
    u_host.close_frame(cpol);
  endtask
  // offer read bytes for n cycles
  task automatic push(input int n);
    rd_valid = 1'b1;
    repeat (n) begin
      rd_data = 8'(8'ha0 + n_push);
      @(negedge sys_clk);
    end
    rd_valid = 1'b0;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  initial begin
    wait_cyc(5);
    rst = 1'b0;
    wait_cyc(3);
    check({rd_ready, swa, dev_rst, sw_busy, pins_out.oe}, 8'hc0);
    frame(8'h05, 1'b0, -1, 1);
    frame(8'h0b, 1'b1, -1, 1);
    frame(8'h9c, 1'b0, 3, 1);
    push(12);
    check(8'(n_push), 8'h08);
    check(8'(rd_ready), 8'h0);
    cfg.quad_enable_bit = 1'b1;
    u_host.quad = 1'b1;
    u_host.open_frame(1'b0);
    u_host.send(8'h6b, 1, -1);
    u_host.recv(4, got);
    check(got, 8'ha0);
    u_host.recv(4, got);
    check(got, 8'ha1);
    u_host.close_frame(1'b0);
    check(8'(rd_ready), 8'h1);
    push(2);
    u_host.open_frame(1'b0);
    u_host.send(8'h3b, 1, -1);
    u_host.recv(2, got);
    check(got, 8'ha8);
    u_host.close_frame(1'b0);
    cfg.quad_enable_bit = 1'b0;
    u_host.quad = 1'b0;
    push(1);
    u_host.open_frame(1'b0);
    u_host.send(8'heb, 1, -1);
    u_host.recv(4, got);
    check(8'(pins_out.oe), 8'h0);
    u_host.close_frame(1'b0);
    cfg.status_protect_bit = 1'b1;
    u_host.wp_n = 1'b0;
    wait_cyc(10);
    check(8'(swa), 8'h0);
    u_host.wp_n = 1'b1;
    wait_cyc(10);
    check(8'(swa), 8'h1);
    // two-byte frame while an internal cycle runs: second byte lands on rx_byte
    ibusy = 1'b1;
    u_host.open_frame(1'b0);
    u_host.send(8'h02, 1, -1);
    u_host.send(8'h5a, 1, -1);
    #200;
    check(rxb, 8'h5a);
    check(8'(lane_mode), 8'h0);
    u_host.close_frame(1'b0);
    ibusy = 1'b0;
    reset_pin_n = 1'b0;
    wait_cyc(16);
    check(8'(dev_rst), 8'h1);
    reset_pin_n = 1'b1;
    wait_cyc(20);
    check(8'(dev_rst), 8'h0);
    frame(8'h66, 1'b0, -1, 1);
    frame(8'h05, 1'b0, -1, 1);
    frame(8'h99, 1'b0, -1, 1);
    check(8'(sw_busy), 8'h0);
    frame(8'h66, 1'b0, -1, 1);
    frame(8'h99, 1'b0, -1, 1);
    check(8'(sw_busy), 8'h1);
    frame(8'h05, 1'b0, -1, 0);
    wait_cyc(450);
    frame(8'h05, 1'b0, -1, 1);
    stop_test();
  end
  // cut a hang short
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
endmodule
